// file: tlo_pkg.sv
// Constants, field layout and mode types of the transmit line output formatter
// Function
// RULE_01 - Digital-rail select and tx line code bit 1 set selects dual-rail outputs.
// RULE_02 - Digital-rail select set with line code bit 1 clear selects optical output.
// RULE_03 - Analog transformer outputs are used only while digital-rail select is clear.
// RULE_04 - Analog outputs float after reset until code bit 1 set, tristate cleared.
// RULE_05 - Digital outputs float after reset until rail select set, tristate cleared.
// RULE_06 - Dual-rail pulses are half-baud when full-baud select is 0, full otherwise.
// RULE_07 - Dual-rail outputs update on rising transmit clock edges in both baud modes.
// RULE_08 - Polarity select sets dual-rail output polarity; active low after reset.
// RULE_09 - Single-rail mode sends unipolar data at 2048 or 1544 kbit/s.
// RULE_10 - NRZ single-rail data is full duty and updates on rising transmit edges.
// RULE_11 - CMI single-rail data updates on both transmit edges per CMI code.
// RULE_12 - Optical data polarity follows polarity select; active high after reset.
// RULE_13 - Frame marker flags the first bit of each frame, aligned with data.
// RULE_14 - Frame marker works only in optical mode.
// RULE_15 - Frame marker updates on rising transmit clock edges with the data.
// RULE_16 - In remote loopback the frame marker is invalid and must be ignored.
// RULE_17 - Receive side uses dual-rail inputs when rail select and rx code bit 1 set.
package tlo_pkg;

  // ==========================================================
  // Register map (byte addresses on the APB)
  localparam logic [7:0] TLO_ADDR_CTRL = 8'h00;
  localparam logic [7:0] TLO_ADDR_STATUS = 8'h04;

  // ==========================================================
  // Control register bit positions and reset value
  localparam int TLO_C_DIG = 0;
  localparam int TLO_C_CODE = 1;
  localparam int TLO_C_TRI = 2;
  localparam int TLO_C_FULL = 3;
  localparam int TLO_C_POL = 4;
  localparam int TLO_C_RXCODE = 5;
  localparam int TLO_C_CMI = 6;
  localparam int TLO_C_RLOOP = 7;
  localparam int TLO_CTRL_W = 8;
  localparam logic [7:0] TLO_CTRL_RESET = 8'h04;

  // ==========================================================
  // Status register bit positions
  localparam int TLO_S_UNDERRUN = 0;
  localparam int TLO_S_DUAL = 1;
  localparam int TLO_S_OPTICAL = 2;
  localparam int TLO_S_ANALOG = 3;
  localparam int TLO_S_RX_DUAL = 4;
  localparam int TLO_S_LEVEL = 8;

  // ==========================================================
  // Line word layout and buffer size
  localparam int TLO_W_DATA = 0;
  localparam int TLO_W_NEG = 1;
  localparam int TLO_W_FIRST = 2;
  localparam int TLO_WORD_W = 3;
  localparam int TLO_FIFO_DEPTH = 8;
  localparam int TLO_LEVEL_W = 4;

  // ==========================================================
  // Line rates, set by the transmit clock that the system supplies
  localparam int TLO_E1_KBPS = 2048;
  localparam int TLO_T1_KBPS = 1544;

  // Output path, one-hot
  typedef enum logic [2:0] {
    TLO_MODE_ANALOG = 3'b001,
    TLO_MODE_DUAL = 3'b010,
    TLO_MODE_OPTICAL = 3'b100
  } tlo_mode_t;

endpackage

// file: tlo_tx_line_output_formatter.sv
// Line-word FIFO and transmit line output formatter with APB registers
`timescale 1ns/1ns

// ==========================================================
// Synchronous FIFO with valid/ready on both sides
module tlo_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 8,
  parameter int LVL_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [LVL_W-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0] wr_ptr_r;
  logic [PW:0] wr_ptr_nxt;
  logic [PW:0] rd_ptr_r;
  logic [PW:0] rd_ptr_nxt;
  logic push;
  logic pop;

  // Full when pointers differ only in the wrap bit
  always_comb begin
    in_ready = (wr_ptr_r[PW] == rd_ptr_r[PW]) || (wr_ptr_r[PW-1:0] != rd_ptr_r[PW-1:0]);
    out_valid = (wr_ptr_r != rd_ptr_r);
    out_data = mem_r[rd_ptr_r[PW-1:0]];
    level = LVL_W'(wr_ptr_r - rd_ptr_r);
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // Storage carries no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r[PW-1:0]] <= in_data;
    end
  end
endmodule

// ==========================================================
// Transmit line output formatter
module tlo_tx_line_output_formatter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transmit_clock,
  input wire logic [tlo_pkg::TLO_WORD_W-1:0] line_word,
  input wire logic line_word_valid,
  output logic line_word_ready,
  output logic tx_analog_line_a,
  output logic tx_analog_line_b,
  output logic tx_analog_oe,
  output logic tx_rail_positive,
  output logic tx_rail_negative,
  output logic tx_rail_oe,
  output logic tx_optical_data,
  output logic tx_optical_oe,
  output logic tx_frame_marker,
  output logic tx_frame_marker_oe,
  output logic rx_dual_rail_select
);

  // ==========================================================
  // Register bus
  logic [tlo_pkg::TLO_CTRL_W-1:0] ctrl_r;
  logic [tlo_pkg::TLO_CTRL_W-1:0] ctrl_nxt;
  logic underrun_r;
  logic underrun_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [31:0] status;
  logic wr_ctrl;
  logic wr_status;
  logic mapped;
  logic [tlo_pkg::TLO_LEVEL_W-1:0] level;

  // Configuration bits by name
  logic dig_sel;
  logic tx_code;
  logic line_tri;
  logic full_baud;
  logic pol_sel;
  logic cmi;
  logic rloop;
  tlo_pkg::tlo_mode_t mode;

  // Zero-wait slave; a bad address is flagged in the access phase
  always_comb begin
    mapped = (paddr == tlo_pkg::TLO_ADDR_CTRL) || (paddr == tlo_pkg::TLO_ADDR_STATUS);
    pready = 1'b1;
    pslverr = psel && penable && !mapped;
    wr_ctrl = psel && penable && pwrite && (paddr == tlo_pkg::TLO_ADDR_CTRL);
    wr_status = psel && penable && pwrite && (paddr == tlo_pkg::TLO_ADDR_STATUS);
    prdata = prdata_r;
  end

  // Field decode of the control register
  always_comb begin
    dig_sel = ctrl_r[tlo_pkg::TLO_C_DIG];
    tx_code = ctrl_r[tlo_pkg::TLO_C_CODE];
    line_tri = ctrl_r[tlo_pkg::TLO_C_TRI];
    full_baud = ctrl_r[tlo_pkg::TLO_C_FULL];
    pol_sel = ctrl_r[tlo_pkg::TLO_C_POL];
    cmi = ctrl_r[tlo_pkg::TLO_C_CMI];
    rloop = ctrl_r[tlo_pkg::TLO_C_RLOOP];
    if (!dig_sel) begin
      mode = tlo_pkg::TLO_MODE_ANALOG; // RULE_03
    end else if (tx_code) begin
      mode = tlo_pkg::TLO_MODE_DUAL; // RULE_01
    end else begin
      mode = tlo_pkg::TLO_MODE_OPTICAL; // RULE_02
    end
  end

  // Status word shows live path and buffer state
  always_comb begin
    status = '0;
    status[tlo_pkg::TLO_S_UNDERRUN] = underrun_r;
    status[tlo_pkg::TLO_S_DUAL] = (mode == tlo_pkg::TLO_MODE_DUAL);
    status[tlo_pkg::TLO_S_OPTICAL] = (mode == tlo_pkg::TLO_MODE_OPTICAL);
    status[tlo_pkg::TLO_S_ANALOG] = (mode == tlo_pkg::TLO_MODE_ANALOG);
    status[tlo_pkg::TLO_S_RX_DUAL] = rx_dual_rail_select;
    status[tlo_pkg::TLO_S_LEVEL +: tlo_pkg::TLO_LEVEL_W] = level;
  end

  // Read data is captured in the setup phase so it comes from flops
  always_comb begin
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    if (wr_ctrl) begin
      ctrl_nxt = pwdata[tlo_pkg::TLO_CTRL_W-1:0];
    end
    if (psel && !penable && !pwrite) begin
      if (paddr == tlo_pkg::TLO_ADDR_CTRL) begin
        prdata_nxt = {{(32 - tlo_pkg::TLO_CTRL_W){1'b0}}, ctrl_r};
      end else if (paddr == tlo_pkg::TLO_ADDR_STATUS) begin
        prdata_nxt = status;
      end else begin
        prdata_nxt = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= tlo_pkg::TLO_CTRL_RESET;
      prdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ==========================================================
  // Transmit clock: synchronised, then edges found on pclk
  logic tclk_s1_r;
  logic tclk_s2_r;
  logic tclk_s3_r;
  logic rise;
  logic fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tclk_s1_r <= 1'b0;
      tclk_s2_r <= 1'b0;
      tclk_s3_r <= 1'b0;
    end else begin
      tclk_s1_r <= transmit_clock;
      tclk_s2_r <= tclk_s1_r;
      tclk_s3_r <= tclk_s2_r;
    end
  end

  // Bit rate is that of the transmit clock, so 2048 or 1544 kbit/s follows it
  always_comb begin
    rise = tclk_s2_r && !tclk_s3_r; // RULE_09
    fall = !tclk_s2_r && tclk_s3_r;
  end

  // ==========================================================
  // Line word buffer
  logic [tlo_pkg::TLO_WORD_W-1:0] head;
  logic head_valid;
  logic take;
  logic run;

  tlo_fifo #(
    .WIDTH(tlo_pkg::TLO_WORD_W),
    .DEPTH(tlo_pkg::TLO_FIFO_DEPTH),
    .LVL_W(tlo_pkg::TLO_LEVEL_W)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_data(line_word),
    .in_valid(line_word_valid),
    .in_ready(line_word_ready),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(take),
    .level(level)
  );

  // ==========================================================
  // Output enables; the buffer only drains while the chosen path drives
  always_comb begin
    tx_analog_oe = !dig_sel && tx_code && !line_tri; // RULE_03 RULE_04
    tx_rail_oe = dig_sel && tx_code && !line_tri; // RULE_01 RULE_05
    tx_optical_oe = dig_sel && !tx_code && !line_tri; // RULE_02 RULE_05
    tx_frame_marker_oe = tx_optical_oe; // RULE_05 RULE_14
    rx_dual_rail_select = dig_sel && ctrl_r[tlo_pkg::TLO_C_RXCODE]; // RULE_17
    run = tx_analog_oe || tx_rail_oe || tx_optical_oe;
    take = rise && run;
  end

  // ==========================================================
  // Bit engine: marks and levels, polarity applied at the pin flops
  logic cur_data_r;
  logic cur_data_nxt;
  logic cmi_alt_r;
  logic cmi_alt_nxt;
  logic pos_r;
  logic pos_nxt;
  logic neg_r;
  logic neg_nxt;
  logic opt_r;
  logic opt_nxt;
  logic fm_r;
  logic fm_nxt;
  logic [tlo_pkg::TLO_WORD_W-1:0] word;

  // Polarity: 0 gives active-low rails and active-high optical data
  function automatic logic rail_pin(input logic mark, input logic pol);
    rail_pin = pol ? mark : !mark;
  endfunction

  function automatic logic opt_pin(input logic lvl, input logic pol);
    opt_pin = pol ? !lvl : lvl;
  endfunction

  // An empty buffer at a bit edge sends an idle zero and flags underrun
  always_comb begin
    word = head_valid ? head : '0;
    cur_data_nxt = cur_data_r;
    cmi_alt_nxt = cmi_alt_r;
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    opt_nxt = opt_r;
    fm_nxt = fm_r;
    underrun_nxt = underrun_r;
    if (wr_status && pwdata[tlo_pkg::TLO_S_UNDERRUN]) begin
      underrun_nxt = 1'b0;
    end
    if (take && !head_valid) begin
      underrun_nxt = 1'b1;
    end
    if (rise) begin
      cur_data_nxt = word[tlo_pkg::TLO_W_DATA];
      pos_nxt = rail_pin(run && word[tlo_pkg::TLO_W_DATA], pol_sel); // RULE_07 RULE_08
      neg_nxt = rail_pin(run && word[tlo_pkg::TLO_W_NEG], pol_sel); // RULE_07 RULE_08
      if (cmi && word[tlo_pkg::TLO_W_DATA]) begin
        opt_nxt = opt_pin(cmi_alt_r, pol_sel); // RULE_11 RULE_12
        cmi_alt_nxt = !cmi_alt_r;
      end else begin
        opt_nxt = opt_pin(!cmi && word[tlo_pkg::TLO_W_DATA], pol_sel); // RULE_10 RULE_12
      end
      fm_nxt = run && word[tlo_pkg::TLO_W_FIRST]; // RULE_13 RULE_15
    end else if (fall) begin
      if (!full_baud) begin
        pos_nxt = rail_pin(1'b0, pol_sel); // RULE_06
        neg_nxt = rail_pin(1'b0, pol_sel); // RULE_06
      end
      if (cmi && !cur_data_r) begin
        opt_nxt = opt_pin(1'b1, pol_sel); // RULE_11
      end
    end
    // Marker held low outside optical mode; loopback makes it meaningless
    if (mode != tlo_pkg::TLO_MODE_OPTICAL || rloop) begin
      fm_nxt = 1'b0; // RULE_14 RULE_16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      underrun_r <= 1'b0;
      cur_data_r <= 1'b0;
      cmi_alt_r <= 1'b0;
      pos_r <= 1'b1;
      neg_r <= 1'b1;
      opt_r <= 1'b0;
      fm_r <= 1'b0;
    end else begin
      underrun_r <= underrun_nxt;
      cur_data_r <= cur_data_nxt;
      cmi_alt_r <= cmi_alt_nxt;
      pos_r <= pos_nxt;
      neg_r <= neg_nxt;
      opt_r <= opt_nxt;
      fm_r <= fm_nxt;
    end
  end

  // Analog path carries the same marks to the external line driver
  always_comb begin
    tx_analog_line_a = pos_r;
    tx_analog_line_b = neg_r;
    tx_rail_positive = pos_r;
    tx_rail_negative = neg_r;
    tx_optical_data = opt_r;
    tx_frame_marker = fm_r;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ctrl_wr_s;
    psel && penable && pwrite && (paddr == tlo_pkg::TLO_ADDR_CTRL);
  endsequence

  sequence dual_fall_s;
    fall && tx_rail_oe && !full_baud;
  endsequence

  sequence cmi_zero_s;
    rise && tx_optical_oe && cmi && head_valid && !head[tlo_pkg::TLO_W_DATA];
  endsequence

  dual_oe_a: assert property (ctrl_wr_s |=> tx_rail_oe == ($past(pwdata[tlo_pkg::TLO_C_DIG])
    && $past(pwdata[tlo_pkg::TLO_C_CODE]) && !$past(pwdata[tlo_pkg::TLO_C_TRI]))) // RULE_01
    else $error("rail enable does not follow written control");

  optical_oe_a: assert property (ctrl_wr_s |=> tx_optical_oe == ($past(pwdata[tlo_pkg::TLO_C_DIG])
    && !$past(pwdata[tlo_pkg::TLO_C_CODE]) && !$past(pwdata[tlo_pkg::TLO_C_TRI]))) // RULE_02
    else $error("optical enable does not follow written control");

  analog_oe_a: assert property (ctrl_wr_s |=> tx_analog_oe == (!$past(pwdata[tlo_pkg::TLO_C_DIG])
    && $past(pwdata[tlo_pkg::TLO_C_CODE]) && !$past(pwdata[tlo_pkg::TLO_C_TRI]))) // RULE_03
    else $error("analog enable does not follow written control");

  reset_float_a: assert property ($rose(presetn) |-> !tx_analog_oe && !tx_rail_oe
    && !tx_optical_oe && !tx_frame_marker_oe) // RULE_04
    else $error("outputs driven right after reset");

  half_baud_a: assert property (dual_fall_s |=> tx_rail_positive == !$past(pol_sel)
    && tx_rail_negative == !$past(pol_sel)) // RULE_06
    else $error("half-baud pulse not ended at falling edge");

  full_edge_a: assert property (tx_rail_oe && $past(full_baud) && $changed(tx_rail_positive)
    && $stable(ctrl_r) |-> $past(rise)) // RULE_07
    else $error("full-baud rail changed without a rising edge");

  nrz_edge_a: assert property (tx_optical_oe && !cmi && $stable(ctrl_r)
    && $changed(tx_optical_data) |-> $past(rise)) // RULE_10
    else $error("NRZ optical data changed off the rising edge");

  cmi_zero_a: assert property (cmi_zero_s ##1 (!fall && !rise) [*1] |->
    tx_optical_data == $past(pol_sel)) // RULE_11
    else $error("CMI zero does not start low");

  marker_align_a: assert property (rise && tx_optical_oe && !rloop && head_valid
    && head[tlo_pkg::TLO_W_FIRST] |=> tx_frame_marker) // RULE_13
    else $error("frame marker missing on first bit");

  marker_mode_a: assert property (mode != tlo_pkg::TLO_MODE_OPTICAL || rloop
    |=> !tx_frame_marker) // RULE_14
    else $error("frame marker active outside optical mode");

endmodule

// file: tlo_line_sink.sv
// Far-side model: the line receiver as it sees the block's output pins
`timescale 1ns/1ns

// ==========================================================
// Line sink with board pull-ups
module tlo_line_sink (
  input wire logic rail_p,
  input wire logic rail_n,
  input wire logic rail_oe,
  input wire logic opt_d,
  input wire logic opt_oe,
  input wire logic mark,
  input wire logic mark_oe,
  output logic rail_p_line,
  output logic rail_n_line,
  output logic opt_line,
  output logic mark_line
);
  // A released pin reads the pull-up, never a stale driven value
  assign rail_p_line = rail_oe ? rail_p : 1'h1;
  assign rail_n_line = rail_oe ? rail_n : 1'h1;
  assign opt_line = opt_oe ? opt_d : 1'h1;
  // Marker only means something while the optical path is driven
  assign mark_line = mark_oe ? mark : 1'h1;
endmodule

// file: test_tx_line_output_formatter.sv
// Self-checking bench for the transmit line output formatter
`timescale 1ns/1ns

// ==========================================================
// Bench top
module test_tx_line_output_formatter;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] pwdata = 32'h0;
  logic transmit_clock = 1'h0;
  logic [tlo_pkg::TLO_WORD_W-1:0] line_word = 3'h0;
  logic line_word_valid = 1'h0;
  logic [31:0] prdata;
  logic pready, pslverr, word_rdy, ana_a, ana_b, ana_oe, rp, rn, r_oe;
  logic od, o_oe, fm, fm_oe, rx_dual, rp_l, rn_l, od_l, fm_l, err;
  logic [31:0] q;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Clock: 50 MHz
  always #10 pclk = ~pclk;

  tlo_tx_line_output_formatter DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .transmit_clock(transmit_clock),
    .line_word(line_word), .line_word_valid(line_word_valid), .line_word_ready(word_rdy),
    .tx_analog_line_a(ana_a), .tx_analog_line_b(ana_b), .tx_analog_oe(ana_oe),
    .tx_rail_positive(rp), .tx_rail_negative(rn), .tx_rail_oe(r_oe),
    .tx_optical_data(od), .tx_optical_oe(o_oe), .tx_frame_marker(fm),
    .tx_frame_marker_oe(fm_oe), .rx_dual_rail_select(rx_dual));

  tlo_line_sink sink (.rail_p(rp), .rail_n(rn), .rail_oe(r_oe), .opt_d(od), .opt_oe(o_oe),
    .mark(fm), .mark_oe(fm_oe), .rail_p_line(rp_l), .rail_n_line(rn_l), .opt_line(od_l),
    .mark_line(fm_l));

  // Compare tasks, one per result width
  task chk1(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s exp %0h got %0h", name, exp, got);
    end
  endtask

  task chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s exp %0h got %0h", name, exp, got);
    end
  endtask

  // APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task ctrl(input logic [7:0] v);
    apb(1'h1, tlo_pkg::TLO_ADDR_CTRL, {24'h0, v});
    repeat (2) @(posedge pclk);
  endtask

  // One line word into the FIFO
  task push(input logic [tlo_pkg::TLO_WORD_W-1:0] w);
    @(posedge pclk);
    line_word <= w;
    line_word_valid <= 1'h1;
    do @(posedge pclk); while (word_rdy !== 1'h1);
    line_word_valid <= 1'h0;
  endtask

  // Bit clock edges; pins settle three pclk edges later
  task tup;
    transmit_clock <= 1'h1;
    repeat (5) @(posedge pclk);
  endtask

  task tdn;
    transmit_clock <= 1'h0;
    repeat (5) @(posedge pclk);
  endtask

  task tbit(input logic [tlo_pkg::TLO_WORD_W-1:0] w);
    push(w);
    tup();
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    chk1("analog_oe", 1'h0, ana_oe);
    chk1("rail_oe", 1'h0, r_oe);
    chk1("opt_oe", 1'h0, o_oe);
    chk1("marker_oe", 1'h0, fm_oe);
    chk1("rail_p", 1'h1, rp);
    chk1("optical", 1'h0, od);
    presetn <= 1'h1;
    apb(1'h0, tlo_pkg::TLO_ADDR_CTRL, 32'h0);
    chk32("ctrl", 32'h00000004, q);
    // Fill while every path is tristated: nothing drains
    for (int i = 0; i < 8; i++) push(3'h1);
    @(posedge pclk);
    chk1("word_ready", 1'h0, word_rdy);
    apb(1'h0, tlo_pkg::TLO_ADDR_STATUS, 32'h0);
    chk32("level", 32'h00000800, q & 32'h00000F00);
    // Dual rail, full baud: each stored mark on the positive rail
    ctrl(8'h0B);
    chk1("rail_oe", 1'h1, r_oe);
    chk1("opt_oe", 1'h0, o_oe);
    chk1("analog_oe", 1'h0, ana_oe);
    for (int i = 0; i < 8; i++) begin
      tup();
      chk1("rail_p", 1'h0, rp_l);
      chk1("rail_n", 1'h1, rn_l);
      tdn();
      chk1("rail_p", 1'h0, rp_l);
    end
    chk1("word_ready", 1'h1, word_rdy);
    tup();
    chk1("rail_p", 1'h1, rp_l);
    tdn();
    apb(1'h0, tlo_pkg::TLO_ADDR_STATUS, 32'h0);
    chk32("status", 32'h00000003, q & 32'h00000F03);
    apb(1'h1, tlo_pkg::TLO_ADDR_STATUS, 32'h1);
    apb(1'h0, tlo_pkg::TLO_ADDR_STATUS, 32'h0);
    chk32("underrun", 32'h0, q & 32'h1);
    // Half baud: negative mark returns to idle after falling edge
    ctrl(8'h03);
    tbit(3'h2);
    chk1("rail_n", 1'h0, rn_l);
    chk1("rail_p", 1'h1, rp_l);
    tdn();
    chk1("rail_n", 1'h1, rn_l);
    // Inverted polarity: marks active high
    ctrl(8'h13);
    tbit(3'h1);
    chk1("rail_p", 1'h1, rp_l);
    chk1("rail_n", 1'h0, rn_l);
    tdn();
    // Analog path enables
    ctrl(8'h02);
    chk1("analog_oe", 1'h1, ana_oe);
    chk1("rail_oe", 1'h0, r_oe);
    // Analog pair carries the marks; half baud returns them to idle
    tbit(3'h1);
    chk1("analog_a", 1'h0, ana_a);
    chk1("analog_b", 1'h1, ana_b);
    tdn();
    chk1("analog_a", 1'h1, ana_a);
    ctrl(8'h06);
    chk1("analog_oe", 1'h0, ana_oe);
    ctrl(8'h00);
    chk1("analog_oe", 1'h0, ana_oe);
    // Optical NRZ with frame marker
    ctrl(8'h01);
    chk1("opt_oe", 1'h1, o_oe);
    chk1("marker_oe", 1'h1, fm_oe);
    chk1("rail_oe", 1'h0, r_oe);
    tbit(3'h5);
    chk1("optical", 1'h1, od_l);
    chk1("marker", 1'h1, fm_l);
    tdn();
    chk1("optical", 1'h1, od_l);
    tbit(3'h0);
    chk1("optical", 1'h0, od_l);
    chk1("marker", 1'h0, fm_l);
    tdn();
    ctrl(8'h11);
    tbit(3'h1);
    chk1("optical", 1'h0, od_l);
    tdn();
    // Remote loopback forces the marker off
    ctrl(8'h81);
    tbit(3'h5);
    chk1("marker", 1'h0, fm_l);
    tdn();
    ctrl(8'h03);
    chk1("marker_oe", 1'h0, fm_oe);
    // CMI: zero is low then high, ones alternate
    ctrl(8'h41);
    tbit(3'h0);
    chk1("cmi_zero_a", 1'h0, od_l);
    tdn();
    chk1("cmi_zero_b", 1'h1, od_l);
    // First one after reset is sent low for the whole bit
    tbit(3'h1);
    chk1("cmi_one", 1'h0, od_l);
    tdn();
    chk1("cmi_one", 1'h0, od_l);
    tbit(3'h1);
    chk1("cmi_alt", 1'h1, od_l);
    tdn();
    // Receive rail select follows rail select and rx code bit 1, not the tx code
    ctrl(8'h21);
    chk1("rx_dual", 1'h1, rx_dual);
    ctrl(8'h20);
    chk1("rx_dual", 1'h0, rx_dual);
    // Unmapped address is refused
    apb(1'h1, 8'h08, 32'hFFFFFFFF);
    chk1("slverr", 1'h1, err);
    apb(1'h0, 8'h08, 32'h0);
    chk32("unmapped", 32'h0, q);
    test_done();
  end
endmodule
